// File: hw/timer_output_compare_unit.sv
// 16-bit timer counter with two output compare channels
`timescale 1ns/100ps
`include "toc_defs.svh"

module timer_output_compare_unit
  import toc_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RESET_N,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR_STB,
  input  wire logic       RD_STB,
  output logic      [7:0] RDATA,
  input  wire logic       TIMER_TICK,
  input  wire logic [2:0] IRQ_ACK,
  output logic      [2:0] IRQ_REQ,
  output logic      [1:0] PIN_OUT,
  output logic      [1:0] PIN_OE
);

  // ----------------------------------------------------------------
  // mode decoding helpers
  // ----------------------------------------------------------------

  // classify the waveform mode; reserved code 13 behaves as normal
  function automatic mode_info_t decode(input logic [3:0] m);
    mode_info_t d;
    d = '{pwm: 1'b1, dual: 1'b0, upd_bottom: 1'b0, top_sel: TOP_FIXED};
    unique case (m)
      4'h0, 4'hD:
      begin
        d.pwm     = 1'b0;
        d.top_sel = TOP_MAX;
      end
      4'h1, 4'h2, 4'h3: d.dual = 1'b1;
      4'h4:
      begin
        d.pwm     = 1'b0;
        d.top_sel = TOP_CMPA;
      end
      4'h5, 4'h6, 4'h7: d.top_sel = TOP_FIXED;
      4'h8, 4'h9:
      begin
        d.dual       = 1'b1;
        d.upd_bottom = 1'b1;
        d.top_sel    = m[0] ? TOP_CMPA : TOP_CAPTURE;
      end
      4'hA, 4'hB:
      begin
        d.dual    = 1'b1;
        d.top_sel = m[0] ? TOP_CMPA : TOP_CAPTURE;
      end
      4'hC:
      begin
        d.pwm     = 1'b0;
        d.top_sel = TOP_CAPTURE;
      end
      4'hE, 4'hF: d.top_sel = m[0] ? TOP_CMPA : TOP_CAPTURE;
    endcase
    return d;
  endfunction

  // new latch value for a non-PWM match or a forced match
  function automatic logic plain_action(input logic [1:0] act, input logic cur);
    logic r;
    r = cur;
    unique case (action_t'(act))
      ACT_NONE:   r = cur;
      ACT_TOGGLE: r = ~cur;
      ACT_CLEAR:  r = 1'b0;
      ACT_SET:    r = 1'b1;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state and derived signals
  // ----------------------------------------------------------------
  toc_state_t  state_reg;
  toc_state_t  state_next;
  mode_info_t  info;
  logic [15:0] top_val;
  logic        tick;
  logic        at_top;
  logic        at_bottom;
  logic [1:0]  hit;
  logic        cnt_write;
  logic [2:0]  flag_set;
  logic [2:0]  flag_clr;

  assign info = decode(state_reg.wgm);

  // clock select zero gates every tick away, the count stays accessible
  assign tick = TIMER_TICK && (state_reg.clk_sel != `TOC_CS_STOP);

  // TOP selection; channel A may define the period
  always_comb
  begin
    unique case (info.top_sel)
      TOP_MAX:     top_val = `TOC_COUNT_MAX;
      TOP_CMPA:    top_val = state_reg.cmp_act[0];
      TOP_CAPTURE: top_val = state_reg.capture;
      TOP_FIXED:   top_val = (state_reg.wgm[1:0] == 2'h1) ? `TOC_TOP_8BIT :
                             (state_reg.wgm[1:0] == 2'h2) ? `TOC_TOP_9BIT :
                             `TOC_TOP_10BIT;
    endcase
  end

  assign at_top    = state_reg.count == top_val;
  assign at_bottom = state_reg.count == `TOC_COUNT_ZERO;
  assign cnt_write = WR_STB && (ADDR == `TOC_OFF_COUNT_L);

  // per channel comparator and pin override
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    // a tick right after a counter write sees no match at all
    assign hit[ch] = tick && !state_reg.block
                     && (state_reg.count == state_reg.cmp_act[ch]);
    // latch drives the pin only with a nonzero action; direction stays with software
    assign PIN_OUT[ch] = (state_reg.action[ch] != 2'h0) ? state_reg.latch[ch]
                                                        : state_reg.pin_data[ch];
    assign PIN_OE[ch]  = state_reg.pin_dir[ch];
  end

  assign IRQ_REQ = state_reg.flags & state_reg.irq_en;
  assign RDATA   = state_reg.rdata;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [15:0] wval;
    logic        buf_load;
    logic        ovf_set;
    state_next = state_reg;
    wval       = {state_reg.temp, WDATA};
    buf_load   = 1'b0;
    ovf_set    = 1'b0;
    flag_set   = 3'h0;
    state_next.rdata = `TOC_READ_IDLE;

    // counting sequence follows the waveform mode only
    if (tick)
    begin
      state_next.block = 1'b0;
      if (info.dual)
      begin
        if (!state_reg.count_down && at_top)
        begin
          state_next.count_down = 1'b1;
          state_next.count      = state_reg.count - 16'h0001;
          buf_load              = !info.upd_bottom;
        end
        else if (state_reg.count_down && at_bottom)
        begin
          state_next.count_down = 1'b0;
          state_next.count      = state_reg.count + 16'h0001;
          ovf_set               = 1'b1;
          buf_load              = info.upd_bottom;
        end
        else
        begin
          state_next.count = state_reg.count_down ? state_reg.count - 16'h0001
                                                  : state_reg.count + 16'h0001;
        end
      end
      else
      begin
        // normal mode has TOP at MAX, so this is a plain wrap to zero
        state_next.count_down = 1'b0;
        state_next.count = at_top ? `TOC_COUNT_ZERO
                                  : state_reg.count + 16'h0001;
        ovf_set  = info.pwm ? at_top
                            : (state_reg.count == `TOC_COUNT_MAX);
        buf_load = info.pwm && at_top;
      end
    end
    flag_set[`TOC_FLAG_OVF] = ovf_set;

    // compare matches and waveform actions per channel
    for (int ch = 0; ch < 2; ch++)
    begin
      if (buf_load)
        state_next.cmp_act[ch] = state_reg.cmp_buf[ch];
      if (hit[ch])
      begin
        flag_set[ch + 1] = 1'b1;
        // action read live, so a fresh setting acts on the next match
        if (!info.pwm)
        begin
          state_next.latch[ch] = plain_action(state_reg.action[ch],
                                              state_reg.latch[ch]);
        end
        else if (state_reg.action[ch] == ACT_CLEAR)
        begin
          state_next.latch[ch] = info.dual && state_reg.count_down;
        end
        else if (state_reg.action[ch] == ACT_SET)
        begin
          state_next.latch[ch] = !(info.dual && state_reg.count_down);
        end
      end
      // single slope PWM restores the level at the wrap, after any match
      if (tick && info.pwm && !info.dual && at_top)
      begin
        if (state_reg.action[ch] == ACT_CLEAR)
          state_next.latch[ch] = 1'b1;
        else if (state_reg.action[ch] == ACT_SET)
          state_next.latch[ch] = 1'b0;
      end
    end

    // force strobe: latch only, never flags or count
    if (WR_STB && (ADDR == `TOC_OFF_FORCE) && !info.pwm)
    begin
      if (WDATA[`TOC_FORCE_A_BIT])
        state_next.latch[0] = plain_action(state_reg.action[0], state_reg.latch[0]);
      if (WDATA[`TOC_FORCE_B_BIT])
        state_next.latch[1] = plain_action(state_reg.action[1], state_reg.latch[1]);
    end

    // flags: service or write-one clears, a coincident set wins
    flag_clr = IRQ_ACK;
    if (WR_STB && (ADDR == `TOC_OFF_FLAGS))
      flag_clr = flag_clr | WDATA[2:0];
    state_next.flags = (state_reg.flags & ~flag_clr) | flag_set;

    // register writes come last so they beat counting
    if (WR_STB)
    begin
      unique case (ADDR)
        `TOC_OFF_CTRL_A:
        begin
          // mode change leaves the latch as it is
          state_next.action[0] = WDATA[7:6];
          state_next.action[1] = WDATA[5:4];
          state_next.wgm[1:0]  = WDATA[1:0];
        end
        `TOC_OFF_CTRL_B:
        begin
          state_next.wgm[3:2] = WDATA[4:3];
          state_next.clk_sel  = WDATA[2:0];
        end
        `TOC_OFF_COUNT_L:
        begin
          state_next.count = wval;
          state_next.block = 1'b1;
        end
        `TOC_OFF_COUNT_H, `TOC_OFF_CMPA_H, `TOC_OFF_CMPB_H, `TOC_OFF_CAP_H:
          state_next.temp = WDATA;
        `TOC_OFF_CMPA_L, `TOC_OFF_CMPB_L:
        begin
          // buffer always follows writes; active only when unbuffered
          state_next.cmp_buf[ADDR == `TOC_OFF_CMPB_L] = wval;
          if (!info.pwm)
          begin
            state_next.cmp_act[ADDR == `TOC_OFF_CMPB_L] = wval;
          end
        end
        `TOC_OFF_CAP_L:  state_next.capture = wval;
        `TOC_OFF_IRQ_EN: state_next.irq_en = WDATA[2:0];
        `TOC_OFF_PIN_CTRL:
        begin
          state_next.pin_dir  = WDATA[1:0];
          state_next.pin_data = WDATA[3:2];
        end
        default:         state_next.temp = state_reg.temp;
      endcase
    end

    // reads answer one cycle later; low byte of count or capture fills temp
    if (RD_STB)
    begin
      unique case (ADDR)
        `TOC_OFF_CTRL_A:
        begin
          state_next.rdata = {state_reg.action[0], state_reg.action[1],
                              2'h0, state_reg.wgm[1:0]};
        end
        `TOC_OFF_CTRL_B: state_next.rdata = {3'h0, state_reg.wgm[3:2], state_reg.clk_sel};
        `TOC_OFF_COUNT_L:
        begin
          state_next.rdata = state_reg.count[7:0];
          state_next.temp  = state_reg.count[15:8];
        end
        `TOC_OFF_CAP_L:
        begin
          state_next.rdata = state_reg.capture[7:0];
          state_next.temp  = state_reg.capture[15:8];
        end
        `TOC_OFF_COUNT_H, `TOC_OFF_CAP_H: state_next.rdata = state_reg.temp;
        `TOC_OFF_CMPA_L: state_next.rdata = state_reg.cmp_buf[0][7:0];
        `TOC_OFF_CMPA_H: state_next.rdata = state_reg.cmp_buf[0][15:8];
        `TOC_OFF_CMPB_L: state_next.rdata = state_reg.cmp_buf[1][7:0];
        `TOC_OFF_CMPB_H: state_next.rdata = state_reg.cmp_buf[1][15:8];
        `TOC_OFF_IRQ_EN: state_next.rdata = {5'h00, state_reg.irq_en};
        `TOC_OFF_FLAGS:  state_next.rdata = {5'h00, state_reg.flags};
        `TOC_OFF_PIN_CTRL: state_next.rdata = {4'h0, state_reg.pin_data, state_reg.pin_dir};
        default:         state_next.rdata = `TOC_READ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // reset clears everything, compare latches included
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_reg <= `TOC_RST_STATE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_match_sets_flag:
  assert property (@(posedge MCLK) disable iff (!RESET_N)
    hit[0] |=> state_reg.flags[1])
  else $error("channel A match did not set its flag");

  chk_block_after_write:
  assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg.block && tick && !WR_STB && IRQ_ACK == 3'h0)
    |=> $stable(state_reg.flags[2:1]))
  else $error("match seen on tick right after counter write");

  chk_irq_request:
  assert property (@(posedge MCLK) disable iff (!RESET_N)
    (IRQ_ACK[1] && !hit[0]) |=> !IRQ_REQ[1])
  else $error("serviced flag still requests an interrupt");

  chk_force_no_flag:
  assert property (@(posedge MCLK) disable iff (!RESET_N)
    (WR_STB && ADDR == `TOC_OFF_FORCE && !tick && IRQ_ACK == 3'h0)
    |=> $stable(state_reg.flags) && $stable(state_reg.count))
  else $error("force strobe touched flags or count");

  chk_action_none_hold:
  assert property (@(posedge MCLK) disable iff (!RESET_N)
    (hit[0] && state_reg.action[0] == 2'h0) |=> $stable(state_reg.latch[0]))
  else $error("latch moved with action none");

  chk_pin_override:
  assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg.action[0] != 2'h0) |-> (PIN_OUT[0] == state_reg.latch[0]))
  else $error("pin not overridden by compare latch");

  chk_normal_wrap:
  assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg.wgm == 4'h0 && tick && state_reg.count == `TOC_COUNT_MAX
     && !WR_STB && IRQ_ACK == 3'h0)
    |=> state_reg.count == `TOC_COUNT_ZERO && state_reg.flags[`TOC_FLAG_OVF])
  else $error("normal mode wrap or overflow flag wrong");

  chk_write_priority:
  assert property (@(posedge MCLK) disable iff (!RESET_N)
    cnt_write |=> state_reg.count == {$past(state_reg.temp), $past(WDATA)})
  else $error("counter write lost to counting");

  chk_set_beats_clear:
  assert property (@(posedge MCLK) disable iff (!RESET_N)
    (hit[0] && (IRQ_ACK[1] || (WR_STB && ADDR == `TOC_OFF_FLAGS && WDATA[1])))
    |=> state_reg.flags[1])
  else $error("flag clear beat coincident set");

  chk_stopped_holds:
  assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg.clk_sel == `TOC_CS_STOP && !cnt_write) |=> $stable(state_reg.count))
  else $error("counter moved while stopped");

endmodule

// File: hw/toc_defs.svh
// register offsets, field positions and reset values of the output compare unit
`ifndef TOC_DEFS_SVH
`define TOC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TOC_OFF_CTRL_A   4'h0
`define TOC_OFF_CTRL_B   4'h1
`define TOC_OFF_FORCE    4'h2
`define TOC_OFF_COUNT_L  4'h3
`define TOC_OFF_COUNT_H  4'h4
`define TOC_OFF_CMPA_L   4'h5
`define TOC_OFF_CMPA_H   4'h6
`define TOC_OFF_CMPB_L   4'h7
`define TOC_OFF_CMPB_H   4'h8
`define TOC_OFF_CAP_L    4'h9
`define TOC_OFF_CAP_H    4'hA
`define TOC_OFF_IRQ_EN   4'hB
`define TOC_OFF_FLAGS    4'hC
`define TOC_OFF_PIN_CTRL 4'hD

// ----------------------------------------------------------------
// field positions and fixed values
// ----------------------------------------------------------------
`define TOC_FORCE_A_BIT  7
`define TOC_FORCE_B_BIT  6
`define TOC_FLAG_OVF     0
`define TOC_CS_STOP      3'h0
`define TOC_COUNT_MAX    16'hFFFF
`define TOC_COUNT_ZERO   16'h0000
`define TOC_TOP_8BIT     16'h00FF
`define TOC_TOP_9BIT     16'h01FF
`define TOC_TOP_10BIT    16'h03FF
`define TOC_RST_STATE    '0
`define TOC_READ_IDLE    8'h00

`endif

// File: hw/toc_pkg.sv
// types shared by the output compare unit
package toc_pkg;

  // output action field codes
  typedef enum logic [1:0] {ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_SET} action_t;

  // where the counter TOP comes from
  typedef enum logic [1:0] {TOP_MAX, TOP_FIXED, TOP_CMPA, TOP_CAPTURE} top_src_t;

  // decoded waveform mode
  typedef struct packed {
    logic     pwm;
    logic     dual;
    logic     upd_bottom;
    top_src_t top_sel;
  } mode_info_t;

  // complete block state
  typedef struct packed {
    logic [15:0]      count;
    logic             count_down;
    logic             block;
    logic [1:0][15:0] cmp_act;
    logic [1:0][15:0] cmp_buf;
    logic [15:0]      capture;
    logic [7:0]       temp;
    logic [1:0]       latch;
    logic [2:0]       flags;
    logic [2:0]       irq_en;
    logic [3:0]       wgm;
    logic [2:0]       clk_sel;
    logic [1:0][1:0]  action;
    logic [1:0]       pin_dir;
    logic [1:0]       pin_data;
    logic [7:0]       rdata;
  } toc_state_t;

endpackage

// File: dv/toc_pin_pad.sv
// pad model of the two compare pins, with the port pull-ups
`timescale 1ns/100ps

module toc_pin_pad
(
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  output logic      [1:0] pad
);

  // ----------------------------------------------------------------
  // pad resolution
  // ----------------------------------------------------------------
  // a released pin goes to the pull-up level, never to the last driven value
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      pad[i] = pin_oe[i] ? pin_out[i] : 1'b1;
  end

endmodule

// File: dv/tb_timer_output_compare_unit.sv
// self-checking testbench of the timer output compare unit
`timescale 1ns/100ps
`include "toc_defs.svh"

module tb_timer_output_compare_unit;

  // ----------------------------------------------------------------
  // signals and table
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] frc;
    logic [7:0] pin;
    logic [1:0] exp;
  } row_t;

  logic       mclk;
  logic       reset_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] rdata;
  logic       tick;
  logic [2:0] irq_ack;
  logic [2:0] irq_req;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] pad;
  logic [7:0] rv;
  int         fail_count = 0;
  int         checked = 0;
  // control, force, pin control, expected pins; latches start at zero
  row_t       rows [7] = '{'{8'hC0, 8'h80, 8'h03, 2'h1}, '{8'h40, 8'h80, 8'h03, 2'h0},
                           '{8'h40, 8'h80, 8'h03, 2'h1}, '{8'h80, 8'h80, 8'h03, 2'h0},
                           '{8'h30, 8'h40, 8'h07, 2'h3}, '{8'h00, 8'hC0, 8'h03, 2'h0},
                           '{8'h50, 8'h00, 8'h03, 2'h2}};

  timer_output_compare_unit u_timer_output_compare_unit (
    .MCLK(mclk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata), .TIMER_TICK(tick), .IRQ_ACK(irq_ack),
    .IRQ_REQ(irq_req), .PIN_OUT(pin_out), .PIN_OE(pin_oe));

  toc_pin_pad u_toc_pin_pad (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  // one-cycle strobes; every signal changes right after a rising edge
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask

  task rdc(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    rv = rdata;
    chk(n, e, rv);
  endtask

  // high byte first so the shared latch is loaded before the low byte
  task wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask

  // ticks two cycles apart; one spare cycle lets flags settle
  task tk(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      tick <= 1'b1;
      @(posedge mclk);
      tick <= 1'b0;
    end
    @(posedge mclk);
    #1;
  endtask

  // a write that lands on the same edge as a timer tick
  task wt(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    tick <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    tick <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // no run may hang: a stuck sequence counts as a mismatch
  initial
  begin
    #40000;
    fail_count++;
    end_of_test;
  end

  initial
  begin
    reset_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    tick = 1'b0;
    irq_ack = 3'h0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    // outputs are looked at off the edge; state still holds its reset values
    chk("pin_out", 8'h00, 8'(pin_out));
    chk("irq_req", 8'h00, 8'(irq_req));
    chk("pad", 8'h03, 8'(pad));
    rdc("unmapped", 4'hE, 8'h00);
    wr(4'hF, 8'hFF);
    rdc("force", `TOC_OFF_FORCE, 8'h00);
    // latch is set up by force strobes before the pins become outputs
    foreach (rows[i])
    begin
      wr(`TOC_OFF_CTRL_A, rows[i].ctl);
      wr(`TOC_OFF_FORCE, rows[i].frc);
      wr(`TOC_OFF_PIN_CTRL, rows[i].pin);
      chk("pin_out", 8'(rows[i].exp), 8'(pin_out));
      chk("pad", 8'(rows[i].exp), 8'(pad));
      chk("pin_oe", 8'(rows[i].pin[1:0]), 8'(pin_oe));
    end
    rdc("flags", `TOC_OFF_FLAGS, 8'h00);
    // normal mode: wrap, overflow, match and toggle
    wr16(`TOC_OFF_CMPB_L, 16'h1234);
    wr16(`TOC_OFF_CMPA_L, 16'h0001);
    wr16(`TOC_OFF_COUNT_L, 16'hFFFE);
    wr(`TOC_OFF_IRQ_EN, 8'h03);
    wr(`TOC_OFF_CTRL_B, 8'h01);
    tk(2);
    chk("irq_req", 8'h01, 8'(irq_req));
    rdc("cnt_l", `TOC_OFF_COUNT_L, 8'h00);
    rdc("cmpb_h", `TOC_OFF_CMPB_H, 8'h12);
    rdc("cnt_h", `TOC_OFF_COUNT_H, 8'h00);
    rdc("cmpb_l", `TOC_OFF_CMPB_L, 8'h34);
    wr(`TOC_OFF_IRQ_EN, 8'h02);
    chk("irq_req", 8'h00, 8'(irq_req));
    wr(`TOC_OFF_IRQ_EN, 8'h03);
    tk(1);
    chk("irq_req", 8'h01, 8'(irq_req));
    tk(1);
    chk("irq_req", 8'h03, 8'(irq_req));
    chk("pin_out", 8'h03, 8'(pin_out));
    @(posedge mclk);
    irq_ack <= 3'h2;
    @(posedge mclk);
    irq_ack <= 3'h0;
    #1;
    chk("irq_req", 8'h01, 8'(irq_req));
    wr(`TOC_OFF_FLAGS, 8'h01);
    chk("irq_req", 8'h00, 8'(irq_req));
    // no action until the mode 15 setup, so matches leave the latches alone
    wr(`TOC_OFF_CTRL_A, 8'h00);
    wr(`TOC_OFF_CTRL_B, 8'h00);
    wr16(`TOC_OFF_COUNT_L, 16'h0001);
    tk(2);
    rdc("cnt_l", `TOC_OFF_COUNT_L, 8'h01);
    wr(`TOC_OFF_CTRL_B, 8'h01);
    tk(1);
    chk("irq_req", 8'h00, 8'(irq_req));
    wr16(`TOC_OFF_COUNT_L, 16'h0000);
    tk(2);
    chk("irq_req", 8'h02, 8'(irq_req));
    wr16(`TOC_OFF_COUNT_L, 16'h0000);
    tk(1);
    wt(`TOC_OFF_FLAGS, 8'h02);
    chk("irq_req", 8'h02, 8'(irq_req));
    wr(`TOC_OFF_FLAGS, 8'h02);
    chk("irq_req", 8'h00, 8'(irq_req));
    wr(`TOC_OFF_COUNT_H, 8'h00);
    wt(`TOC_OFF_COUNT_L, 8'h40);
    rdc("cnt_l", `TOC_OFF_COUNT_L, 8'h40);
    // mode 15: top from compare A, compare B double buffered
    wr16(`TOC_OFF_CMPA_L, 16'h0010);
    wr(`TOC_OFF_CTRL_A, 8'h53);
    chk("pin_out", 8'h03, 8'(pin_out));
    wr(`TOC_OFF_CTRL_B, 8'h19);
    chk("pin_out", 8'h03, 8'(pin_out));
    wr(`TOC_OFF_IRQ_EN, 8'h04);
    wr16(`TOC_OFF_CMPB_L, 16'h0003);
    rdc("cmpb_l", `TOC_OFF_CMPB_L, 8'h03);
    wr16(`TOC_OFF_COUNT_L, 16'h0002);
    tk(2);
    chk("irq_req", 8'h00, 8'(irq_req));
    tk(13);
    rdc("cnt_l", `TOC_OFF_COUNT_L, 8'h00);
    tk(3);
    chk("irq_req", 8'h00, 8'(irq_req));
    tk(1);
    chk("irq_req", 8'h04, 8'(irq_req));
    // mid-run reset: both latches are high here and must come back low
    @(posedge mclk);
    reset_n <= 1'b0;
    @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk("irq_req", 8'h00, 8'(irq_req));
    wr(`TOC_OFF_CTRL_A, 8'h50);
    chk("pin_out", 8'h00, 8'(pin_out));
    end_of_test;
  end

endmodule
